// [common/serial_cfg_regs.svh]
// Register offsets, field positions, reset values and timing counts of the port setup block
`ifndef SERIAL_CFG_REGS_SVH
`define SERIAL_CFG_REGS_SVH

// ============================================================
// Register offsets (byte addresses, one word each)
`define REG_NV_ADDR       8'h00
`define REG_NV_RATE       8'h04
`define REG_CTRL          8'h08
`define REG_STATUS        8'h0C
`define REG_SNAPSHOT      8'h10
`define REG_ACTIVE        8'h14

// ============================================================
// Field positions
`define CTRL_GO_BIT       0
`define STAT_VALID_BIT    0
`define STAT_RS485_BIT    1
`define STAT_WAIT_BIT     2
`define SNAP_STRAP_BIT    8
`define ACT_ADDR_LSB      0
`define ACT_RATE_LSB      8
`define ACT_ADDR_NV_BIT   16
`define ACT_RATE_NV_BIT   17

// ============================================================
// Reset values
`define NV_ADDR_RST       6'h00
`define NV_RATE_RST       2'h1

// ============================================================
// Encodings
`define STRAP_RS485_LVL   1'b0
`define ADDR_FROM_NV      6'h00
`define RATE_FROM_NV      2'h0
`define RATE_9K6          2'h1
`define RATE_38K4         2'h2
`define RATE_115K2        2'h3

// ============================================================
// Timing
`define SETTLE_CYC        4'h3
`define CLK_HZ            20000000
`define BPS_9K6           9600
`define BPS_38K4          38400
`define BPS_115K2         115200
`define BIT_CYC_9K6       12'(`CLK_HZ / `BPS_9K6)
`define BIT_CYC_38K4      12'(`CLK_HZ / `BPS_38K4)
`define BIT_CYC_115K2     12'(`CLK_HZ / `BPS_115K2)

`endif

// [common/serial_cfg_pkg.sv]
// Types shared by the port setup block
package serial_cfg_pkg;

  // ============================================================
  // Sequencer states
  typedef enum logic [1:0] {
    ST_SETTLE  = 2'b00,
    ST_WAIT_GO = 2'b01,
    ST_RUN     = 2'b10
  } cfg_state_e;

  // ============================================================
  // Resolved port setup
  typedef struct packed {
    logic       rs485;
    logic [5:0] addr;
    logic [1:0] rate;
  } port_cfg_s;

  // Pin levels caught once after reset
  typedef struct packed {
    logic       strap;
    logic [7:0] sw;
  } pin_snap_s;

  typedef logic [11:0] bit_cyc_t;

endpackage

// [rtl/pin_sync.sv]
// Two-flop synchroniser bank for the strap and switch pins
module pin_sync #(
  parameter int WIDTH = 9
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // Asynchronous pins and their synchronised copy
  input  wire logic [WIDTH-1:0] pins_async,
  output logic      [WIDTH-1:0] pins_sync
);

  logic [WIDTH-1:0] stage_one;

  // ============================================================
  // One pair of flops per pin; first stage feeds only the second
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          stage_one[i] <= 1'b0;
          pins_sync[i] <= 1'b0;
        end else begin
          stage_one[i] <= pins_async[i];
          pins_sync[i] <= stage_one[i];
        end
      end
    end
  endgenerate

endmodule

// [rtl/serial_port_config_select.sv]
// Serial port setup: strap and switch capture, address and bit-rate resolution
//
// Summary of operation
// - Strap at ground selects RS-485, otherwise RS-232; installer drives it.
// - Switches one to six form the 6-bit node address, switch one LSB.
// - Switches seven and eight form the 2-bit rate code, seven low.
// - Switch address and rate matter only in RS-485 mode.
// - Zero address or zero rate field takes the stored value, independently.
// - Rate codes 1, 2, 3 mean 9.6, 38.4 and 115.2 kbps.
`include "serial_cfg_regs.svh"

module serial_port_config_select (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      reset_n,
  // Pins: strap low selects RS-485, switch on reads 1
  input  wire logic                      iface_select,
  input  wire logic [7:0]                sw_pins,
  // Register port
  input  wire logic [7:0]                bus_addr,
  input  wire logic [31:0]               bus_wdata,
  input  wire logic                      bus_wr,
  input  wire logic                      bus_rd,
  output logic      [31:0]               bus_rdata,
  // Resolved setup for the serial engine
  output serial_cfg_pkg::port_cfg_s      port_cfg,
  output serial_cfg_pkg::bit_cyc_t       bit_cycles,
  output logic                           config_valid
);

  // ============================================================
  // Declarations
  logic [8:0]                  pins_sync;
  serial_cfg_pkg::pin_snap_s   pins_now;
  serial_cfg_pkg::cfg_state_e  state;
  serial_cfg_pkg::cfg_state_e  next_state;
  logic [3:0]                  settle_cnt;
  logic [3:0]                  next_settle_cnt;
  serial_cfg_pkg::pin_snap_s   snap;
  serial_cfg_pkg::pin_snap_s   next_snap;
  serial_cfg_pkg::port_cfg_s   next_port_cfg;
  serial_cfg_pkg::bit_cyc_t    next_bit_cycles;
  logic                        next_config_valid;
  logic                        addr_nv;
  logic                        next_addr_nv;
  logic                        rate_nv;
  logic                        next_rate_nv;
  logic [5:0]                  nv_addr;
  logic [5:0]                  next_nv_addr;
  logic [1:0]                  nv_rate;
  logic [1:0]                  next_nv_rate;
  logic [31:0]                 next_bus_rdata;
  logic                        go_wr;
  logic                        snap_rs485;
  logic [5:0]                  sw_addr;
  logic [1:0]                  sw_rate;
  logic [1:0]                  nv_rate_eff;

  // ============================================================
  // Rate code to bit period in clock cycles
  function automatic serial_cfg_pkg::bit_cyc_t rate_to_cycles(input logic [1:0] code);
    serial_cfg_pkg::bit_cyc_t cyc;
    if (code == `RATE_38K4) begin
      cyc = `BIT_CYC_38K4;
    end else if (code == `RATE_115K2) begin
      cyc = `BIT_CYC_115K2;
    end else begin
      cyc = `BIT_CYC_9K6;
    end
    return cyc;
  endfunction

  // ============================================================
  // Pin synchronisers; pins are set by hand and change at any time
  pin_sync #(
    .WIDTH (9)
  ) u_pin_sync (
    .clk        (clk),
    .reset_n    (reset_n),
    .pins_async ({iface_select, sw_pins}),
    .pins_sync  (pins_sync)
  );

  assign pins_now = pins_sync;

  // ============================================================
  // Field views of the snapshot
  assign snap_rs485  = (snap.strap == `STRAP_RS485_LVL);
  assign sw_addr     = snap.sw[5:0];
  assign sw_rate     = snap.sw[7:6];
  // A stored rate of zero has no meaning; fall back to the slowest rate
  assign nv_rate_eff = (nv_rate == `RATE_FROM_NV) ? `RATE_9K6 : nv_rate;

  // Software releases the resolution once stored values are loaded
  assign go_wr = bus_wr && (bus_addr == `REG_CTRL) && bus_wdata[`CTRL_GO_BIT];

  // ============================================================
  // Sequencer: settle, snapshot, wait for stored values, resolve
  always_comb begin
    next_state        = state;
    next_settle_cnt   = settle_cnt;
    next_snap         = snap;
    next_port_cfg     = port_cfg;
    next_bit_cycles   = bit_cycles;
    next_config_valid = config_valid;
    next_addr_nv      = addr_nv;
    next_rate_nv      = rate_nv;
    case (state)
      serial_cfg_pkg::ST_SETTLE: begin
        // Wait until the synchroniser holds real pin levels
        if (settle_cnt == `SETTLE_CYC) begin
          next_snap  = pins_now;
          next_state = serial_cfg_pkg::ST_WAIT_GO;
        end else begin
          next_settle_cnt = settle_cnt + 4'h1;
        end
      end
      serial_cfg_pkg::ST_WAIT_GO: begin
        if (go_wr) begin
          next_port_cfg.rs485 = snap_rs485;
          // Switches count only in RS-485 mode; zero picks stored value
          next_addr_nv = !snap_rs485 || (sw_addr == `ADDR_FROM_NV);
          next_rate_nv = !snap_rs485 || (sw_rate == `RATE_FROM_NV);
          next_port_cfg.addr = next_addr_nv ? nv_addr : sw_addr;
          next_port_cfg.rate = next_rate_nv ? nv_rate_eff : sw_rate;
          next_bit_cycles    = rate_to_cycles(next_port_cfg.rate);
          next_config_valid  = 1'b1;
          next_state         = serial_cfg_pkg::ST_RUN;
        end
      end
      serial_cfg_pkg::ST_RUN: begin
        // Held until the next reset
        next_state = serial_cfg_pkg::ST_RUN;
      end
      default: begin
        next_state = serial_cfg_pkg::ST_SETTLE;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state        <= serial_cfg_pkg::ST_SETTLE;
      settle_cnt   <= 4'h0;
      snap         <= '0;
      port_cfg     <= '0;
      bit_cycles   <= 12'h000;
      config_valid <= 1'b0;
      addr_nv      <= 1'b0;
      rate_nv      <= 1'b0;
    end else begin
      state        <= next_state;
      settle_cnt   <= next_settle_cnt;
      snap         <= next_snap;
      port_cfg     <= next_port_cfg;
      bit_cycles   <= next_bit_cycles;
      config_valid <= next_config_valid;
      addr_nv      <= next_addr_nv;
      rate_nv      <= next_rate_nv;
    end
  end

  // ============================================================
  // Stored values, written by software from non-volatile memory
  always_comb begin
    next_nv_addr = nv_addr;
    next_nv_rate = nv_rate;
    if (bus_wr && (bus_addr == `REG_NV_ADDR)) begin
      next_nv_addr = bus_wdata[5:0];
    end else if (bus_wr && (bus_addr == `REG_NV_RATE)) begin
      next_nv_rate = bus_wdata[1:0];
    end
  end

  // Stored value registers; later writes do not touch the held setup
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      nv_addr <= `NV_ADDR_RST;
      nv_rate <= `NV_RATE_RST;
    end else begin
      nv_addr <= next_nv_addr;
      nv_rate <= next_nv_rate;
    end
  end

  // ============================================================
  // Read data, valid only in the cycle after the strobe
  always_comb begin
    next_bus_rdata = 32'h0000_0000;
    if (bus_rd) begin
      if (bus_addr == `REG_NV_ADDR) begin
        next_bus_rdata[5:0] = nv_addr;
      end else if (bus_addr == `REG_NV_RATE) begin
        next_bus_rdata[1:0] = nv_rate;
      end else if (bus_addr == `REG_STATUS) begin
        next_bus_rdata[`STAT_VALID_BIT] = config_valid;
        next_bus_rdata[`STAT_RS485_BIT] = port_cfg.rs485;
        next_bus_rdata[`STAT_WAIT_BIT]  = (state == serial_cfg_pkg::ST_WAIT_GO);
      end else if (bus_addr == `REG_SNAPSHOT) begin
        next_bus_rdata[7:0]             = snap.sw;
        next_bus_rdata[`SNAP_STRAP_BIT] = snap.strap;
      end else if (bus_addr == `REG_ACTIVE) begin
        next_bus_rdata[`ACT_ADDR_LSB +: 6] = port_cfg.addr;
        next_bus_rdata[`ACT_RATE_LSB +: 2] = port_cfg.rate;
        next_bus_rdata[`ACT_ADDR_NV_BIT]   = addr_nv;
        next_bus_rdata[`ACT_RATE_NV_BIT]   = rate_nv;
      end else begin
        // Unmapped and write-only offsets read as zero
        next_bus_rdata = 32'h0000_0000;
      end
    end
  end

  // Read data register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      bus_rdata <= 32'h0000_0000;
    end else begin
      bus_rdata <= next_bus_rdata;
    end
  end

  // ============================================================
  // Checks on the resolved setup
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_mode_from_strap: assert property ($rose(config_valid) |->
    port_cfg.rs485 == (snap.strap == `STRAP_RS485_LVL))
    else $error("port mode does not follow the strap");

  a_addr_bit_order: assert property ($rose(config_valid) && port_cfg.rs485
    && (snap.sw[5:0] != `ADDR_FROM_NV) |-> port_cfg.addr == snap.sw[5:0])
    else $error("node address not taken from switches one to six");

  a_rate_bit_order: assert property ($rose(config_valid) && port_cfg.rs485
    && (snap.sw[7:6] != `RATE_FROM_NV) |-> port_cfg.rate == snap.sw[7:6])
    else $error("rate code not taken from switches seven and eight");

  a_rs232_ignores_switches: assert property ($rose(config_valid)
    && !port_cfg.rs485 |-> port_cfg.addr == nv_addr && port_cfg.rate == nv_rate_eff)
    else $error("switches affected RS-232 setup");

  a_addr_zero_fallback: assert property ($rose(config_valid)
    && port_cfg.rs485 && (snap.sw[5:0] == `ADDR_FROM_NV) |-> port_cfg.addr == nv_addr)
    else $error("zero switch address did not take stored address");

  a_rate_zero_fallback: assert property ($rose(config_valid)
    && port_cfg.rs485 && (snap.sw[7:6] == `RATE_FROM_NV) |-> port_cfg.rate == nv_rate_eff)
    else $error("zero switch rate did not take stored rate");

  a_rate_decode: assert property (config_valid |->
    bit_cycles == rate_to_cycles(port_cfg.rate) && port_cfg.rate != `RATE_FROM_NV)
    else $error("bit period does not match rate code");

  a_setup_held: assert property (config_valid |=>
    config_valid && $stable(port_cfg) && $stable(bit_cycles) && $stable(snap))
    else $error("setup changed after it was resolved");

  a_snap_timing: assert property ($fell(state == serial_cfg_pkg::ST_SETTLE)
    |-> snap == $past(pins_now))
    else $error("snapshot not taken from synchronised pins");

  a_go_resolves: assert property (state == serial_cfg_pkg::ST_WAIT_GO && go_wr
    |=> config_valid && state == serial_cfg_pkg::ST_RUN)
    else $error("go write did not resolve the setup");

  // ============================================================
  // Bus and sequencing checks
  // Stale read data would be taken by a master that samples late
  a_rdata_idle: assert property (!bus_rd |=> bus_rdata == 32'h0000_0000)
    else $error("read data stood without a read strobe");

  a_zero_until_valid: assert property (!config_valid |->
    port_cfg == 9'h000 && bit_cycles == 12'h000)
    else $error("setup outputs moved before resolution");

  // A go write before the pins are caught must leave no trace
  a_early_go_ignored: assert property (state == serial_cfg_pkg::ST_SETTLE && go_wr
    |=> !config_valid)
    else $error("go write acted on before the pins were caught");

  a_snap_held: assert property (state != serial_cfg_pkg::ST_SETTLE |=> $stable(snap))
    else $error("snapshot changed after it was taken");

  a_settle_bound: assert property (settle_cnt <= `SETTLE_CYC)
    else $error("settle counter ran past its end");

  a_valid_in_run: assert property (config_valid == (state == serial_cfg_pkg::ST_RUN))
    else $error("valid flag and sequencer state disagree");

  c_rs485_switch_setup: cover property ($rose(config_valid) && port_cfg.rs485 && !addr_nv);
  c_rs485_stored_setup: cover property ($rose(config_valid) && port_cfg.rs485 && addr_nv
    && rate_nv);
  c_rs232_setup: cover property ($rose(config_valid) && !port_cfg.rs485);
  c_fast_rate: cover property (config_valid && port_cfg.rate == `RATE_115K2);
  c_early_go: cover property (state == serial_cfg_pkg::ST_SETTLE && go_wr);

endmodule

// [sim/switch_panel.sv]
// Installer side model: strap pin and eight hardware switches
module switch_panel (
  // Clock
  input  wire logic       clk,
  // Settings chosen by the bench
  input  wire logic       strap_set,
  input  wire logic [7:0] sw_set,
  // Pins toward the drive
  output logic            iface_select,
  output logic [7:0]      sw_pins
);
  timeunit 1ns;
  timeprecision 1ns;

  // Pins move just after an edge; a real strap is a slow level, never a pulse
  always @(posedge clk) begin
    iface_select <= strap_set;
    sw_pins      <= sw_set;
  end
endmodule

// [sim/serial_port_config_select_bench.sv]
// Self-checking bench for the serial port setup block
`include "serial_cfg_regs.svh"

module serial_port_config_select_bench;
  timeunit 1ns;
  timeprecision 1ns;

  // ============================================================
  // Signals
  logic                      clk, reset_n, bus_wr, bus_rd, strap_set;
  logic                      iface_select, config_valid;
  logic [7:0]                bus_addr, sw_set, sw_pins;
  logic [31:0]               bus_wdata, bus_rdata;
  serial_cfg_pkg::port_cfg_s port_cfg;
  serial_cfg_pkg::bit_cyc_t  bit_cycles;
  int                        n_errors, comparisons, cycles;

  // Case table: strap, switches, stored address, stored rate
  logic       cs  [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
  logic [7:0] csw [6] = '{8'h45, 8'h80, 8'hFF, 8'h20, 8'hFF, 8'h00};
  logic [5:0] cna [6] = '{6'h2A, 6'h2A, 6'h15, 6'h15, 6'h11, 6'h00};
  logic [1:0] cnr [6] = '{2'h2, 2'h3, 2'h1, 2'h3, 2'h2, 2'h0};

  // ============================================================
  // Instances
  switch_panel panel_u (.clk(clk), .strap_set(strap_set), .sw_set(sw_set),
                        .iface_select(iface_select), .sw_pins(sw_pins));

  serial_port_config_select dut_u (
    .clk(clk), .reset_n(reset_n), .iface_select(iface_select), .sw_pins(sw_pins),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .port_cfg(port_cfg), .bit_cycles(bit_cycles),
    .config_valid(config_valid));

  // Clock, 50 ns period
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Hang guard; a full run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      $display("ERROR at %0t: timeout", $time);
      results();
    end
  end

  // ============================================================
  // Tasks
  task automatic results();
    if (n_errors == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_wr    <= 1'b1;
    bus_addr  <= a;
    bus_wdata <= d;
    @(posedge clk);
    bus_wr    <= 1'b0;
  endtask

  // Data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd_raw(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    bus_rd   <= 1'b1;
    bus_addr <= a;
    @(posedge clk);
    bus_rd   <= 1'b0;
    #1 d = bus_rdata;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd_raw(a, d);
    chk(d, exp);
  endtask

  task automatic do_reset();
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
  endtask

  // One full setup: pins, early GO, stored values, GO, then a disturbance that must not show
  task automatic run_case(input int i);
    logic        rs, an, rn;
    logic [5:0]  ea;
    logic [1:0]  er;
    logic [11:0] ec;
    logic [31:0] st, outv;
    int          k;
    rs = (cs[i] == `STRAP_RS485_LVL);
    an = !(rs && csw[i][5:0] != 6'h00);
    rn = !(rs && csw[i][7:6] != 2'h0);
    ea = an ? cna[i] : csw[i][5:0];
    // A stored rate of zero falls back to the slowest rate
    er = rn ? ((cnr[i] == 2'h0) ? 2'h1 : cnr[i]) : csw[i][7:6];
    ec = (er == 2'h1) ? 12'(`CLK_HZ / `BPS_9K6) :
         (er == 2'h2) ? 12'(`CLK_HZ / `BPS_38K4) : 12'(`CLK_HZ / `BPS_115K2);
    outv = {10'h000, 1'b1, rs, ea, er, ec};
    @(posedge clk);
    strap_set <= cs[i];
    sw_set    <= csw[i];
    do_reset();
    wr(`REG_CTRL, 32'h1);
    wr(`REG_NV_ADDR, {26'h0, cna[i]});
    wr(`REG_NV_RATE, {30'h0, cnr[i]});
    k = 0;
    do begin
      rd_raw(`REG_STATUS, st);
      k++;
    end while (st[2] !== 1'b1 && k < 20);
    chk(st, 32'h0000_0004);
    chk({31'h0, config_valid}, 32'h0);
    rd(`REG_SNAPSHOT, {23'h0, cs[i], csw[i]});
    wr(`REG_CTRL, 32'h1);
    #1 chk({10'h000, config_valid, port_cfg, bit_cycles}, outv);
    rd(`REG_ACTIVE, {14'h0, rn, an, 6'h0, er, 2'h0, ea});
    rd(`REG_STATUS, {29'h0, 1'b0, rs, 1'b1});
    // Flip everything after the setup resolved
    strap_set <= ~cs[i];
    sw_set    <= ~csw[i];
    wr(`REG_NV_ADDR, {26'h0, ~cna[i]});
    wr(`REG_NV_RATE, {30'h0, ~cnr[i]});
    wr(`REG_CTRL, 32'h1);
    repeat (6) @(posedge clk);
    #1 chk({10'h000, config_valid, port_cfg, bit_cycles}, outv);
  endtask

  // ============================================================
  // Main sequence
  initial begin
    reset_n     = 1'b0;
    bus_wr      = 1'b0;
    bus_rd      = 1'b0;
    bus_addr    = 8'h00;
    bus_wdata   = 32'h0;
    strap_set   = 1'b1;
    sw_set      = 8'h00;
    n_errors    = 0;
    comparisons = 0;
    cycles      = 0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    // Register reset values, masking and unmapped places
    rd(`REG_NV_ADDR, 32'h0);
    rd(`REG_NV_RATE, 32'h1);
    rd(`REG_CTRL, 32'h0);
    rd(8'h18, 32'h0);
    wr(`REG_NV_ADDR, 32'hFFFFFFFF);
    rd(`REG_NV_ADDR, 32'h3F);
    for (int i = 0; i < 6; i++)
      run_case(i);
    results();
  end
endmodule
